// [include/lin_regs_pkg.sv]
// Register map, field positions and reset values of the LIN/UART register set
package lin_regs_pkg;
	localparam logic [7:0] OFF_STATUS   = 8'hc9;
	localparam logic [7:0] OFF_IRQ_EN   = 8'hca;
	localparam logic [7:0] OFF_ERROR    = 8'hcb;
	localparam logic [7:0] OFF_TIMING   = 8'hcc;
	localparam logic [7:0] OFF_DIV_LOW  = 8'hcd;
	localparam logic [7:0] OFF_DIV_HIGH = 8'hce;
	localparam logic [7:0] OFF_LENGTH   = 8'hcf;
	localparam logic [7:0] OFF_IDENT    = 8'hd0;
	localparam logic [7:0] OFF_SELECT   = 8'hd1;
	localparam logic [7:0] OFF_DATA     = 8'hd2;
	localparam logic [7:0] OFF_CONTROL  = 8'hc8;

	localparam int BIT_ERR  = 3;
	localparam int BIT_ID   = 2;
	localparam int BIT_TX   = 1;
	localparam int BIT_RX   = 0;
	localparam int BIT_RESYNC_OFF = 7;
	localparam int BIT_AUTOINC_OFF = 3;
	localparam int BIT_LEGACY = 6;
	localparam int BIT_UART   = 0;

	localparam logic [5:0] SAMPLES_RESET = 6'h20;
	localparam logic [5:0] SAMPLES_MIN   = 6'h08;
	localparam logic [3:0] BYTES_MAX     = 4'h8;
	localparam logic [3:0] LEN_TWO       = 4'h2;
	localparam logic [3:0] LEN_FOUR      = 4'h4;
	localparam logic [3:0] LEN_EIGHT     = 4'h8;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;
	localparam int BUF_DEPTH = 8;

	typedef enum logic [1:0]
	{
		LEN_CODE_2A = 2'b00,
		LEN_CODE_2B = 2'b01,
		LEN_CODE_4  = 2'b10,
		LEN_CODE_8  = 2'b11
	} legacy_len_e;

	// Error events from the protocol engine, one bit per flag, bit 7 down to 0
	typedef struct packed
	{
		logic abortFlag;
		logic frameTimeoutFlag;
		logic overrunFlag;
		logic framingFlag;
		logic syncErrorFlag;
		logic parityErrorFlag;
		logic checksumErrorFlag;
		logic bitErrorFlag;
	} err_events_s;

	// Completion events from the protocol engine
	typedef struct packed
	{
		logic identOk;
		logic txDone;
		logic rxDone;
	} done_events_s;

	// Timing settings handed to the engine
	typedef struct packed
	{
		logic       resyncEnable;
		logic [5:0] samplesPerBit;
		logic       sampleTick;
	} timing_s;
endpackage

// [core/lin_uart_register_set.sv]
// Register set of the LIN/UART controller with baud tick and response buffer
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - Error interrupt forwarded only when enable bit 3 set.
// - Identifier interrupt forwarded only when enable bit 2 set.
// - Transmit-done interrupt forwarded only when enable bit 1 set.
// - Receive-done interrupt forwarded only when enable bit 0 set.
// - Error bit 7 set on abort command, zero otherwise.
// - Error bits 6,5,4: frame timeout, overrun, framing.
// - Error bits 3..0: sync, parity, checksum, bit error.
// - Clearing summary error flag clears all error flags; reset zero.
// - Timing bit 7 one disables resynchronisation; default zero enables.
// - Six-bit samples per bit, default 32, min 8, max 63.
// - Sample period lasts divider plus one clock cycles.
// - Revision 2.1 LIN mode transmit count from length bits 7:4, clamped to 8.
// - Revision 2.1 LIN mode receive count from length bits 3:0, clamped to 8.
// - Revision 1.3 length code: 00/01 two, 10 four, 11 eight bytes.
// - Revision 1.3 identifier is bits 3:0.
// - Revision 2.1 identifier is bits 5:0, no length.
// - LIN mode select bit 3 zero auto-increments index, one holds it.
// - LIN mode index bits 2:0 choose buffer byte for data port.
// - UART mode data port is one unbuffered byte; LIN mode buffer port.
// - Summary error flag is OR of error flags, cleared by writing one.
// - Status flags raise controller interrupt when enabled.
// - Control bit 6 selects revision 1.3; zero selects 2.1.
module lin_uart_register_set
(
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	// Register port
	input  wire logic [7:0]                  regAddr,
	input  wire logic [7:0]                  regWrData,
	input  wire logic                        regWrStrobe,
	input  wire logic                        regRdStrobe,
	output logic      [7:0]                  regRdData,
	// Protocol engine events
	input  wire lin_regs_pkg::err_events_s   errEvents,
	input  wire lin_regs_pkg::done_events_s  doneEvents,
	input  wire logic                        uartRxValid,
	input  wire logic [7:0]                  uartRxByte,
	input  wire logic                        respWrValid,
	input  wire logic [2:0]                  respWrIndex,
	input  wire logic [7:0]                  respWrByte,
	input  wire logic [2:0]                  respRdIndex,
	// Configuration toward the engine
	output lin_regs_pkg::timing_s            timing,
	output logic                             uartMode,
	output logic                             legacyRevision,
	output logic      [3:0]                  txByteCount,
	output logic      [3:0]                  rxByteCount,
	output logic      [5:0]                  identValue,
	output logic      [7:0]                  respRdByte,
	output logic      [7:0]                  uartTxByte,
	output logic                             uartTxLoad,
	// Controller interrupt
	output logic                             irq
);
	logic [7:0]  controlQ;
	logic [3:0]  irqEnQ;
	logic [7:0]  errQ;
	logic        idOkQ;
	logic        txDoneQ;
	logic        rxDoneQ;
	logic        resyncOffQ;
	logic [5:0]  samplesQ;
	logic [11:0] divQ;
	logic [7:0]  lengthQ;
	logic [7:0]  identQ;
	logic        autoIncOffQ;
	logic [2:0]  indexQ;
	logic [7:0]  uartRxQ;
	logic [7:0]  uartTxQ;
	logic        uartTxLoadQ;
	logic [7:0]  respBuf [lin_regs_pkg::BUF_DEPTH];
	logic [11:0] divCntQ;
	logic        tickQ;
	logic [7:0]  rdDataQ;
	logic        summaryErr;
	logic        errClear;
	logic        dataWr;
	logic        dataRd;
	logic [3:0]  legacyLen;
	logic [7:0]  statusView;
	logic [7:0]  rdMux;
	logic        wrControl;
	logic        wrStatus;
	logic        wrIrqEn;
	logic        wrTiming;
	logic        wrDivLow;
	logic        wrDivHigh;
	logic        wrLength;
	logic        wrIdent;
	logic        wrSelect;

	assign dataWr = regWrStrobe && (regAddr == lin_regs_pkg::OFF_DATA);
	assign dataRd = regRdStrobe && (regAddr == lin_regs_pkg::OFF_DATA);
	// One write enable per register keeps the address decode in one place
	assign wrControl = regWrStrobe && (regAddr == lin_regs_pkg::OFF_CONTROL);
	assign wrStatus  = regWrStrobe && (regAddr == lin_regs_pkg::OFF_STATUS);
	assign wrIrqEn   = regWrStrobe && (regAddr == lin_regs_pkg::OFF_IRQ_EN);
	assign wrTiming  = regWrStrobe && (regAddr == lin_regs_pkg::OFF_TIMING);
	assign wrDivLow  = regWrStrobe && (regAddr == lin_regs_pkg::OFF_DIV_LOW);
	assign wrDivHigh = regWrStrobe && (regAddr == lin_regs_pkg::OFF_DIV_HIGH);
	assign wrLength  = regWrStrobe && (regAddr == lin_regs_pkg::OFF_LENGTH);
	assign wrIdent   = regWrStrobe && (regAddr == lin_regs_pkg::OFF_IDENT);
	assign wrSelect  = regWrStrobe && (regAddr == lin_regs_pkg::OFF_SELECT);
	assign uartMode = controlQ[lin_regs_pkg::BIT_UART];
	assign legacyRevision = controlQ[lin_regs_pkg::BIT_LEGACY];
	assign summaryErr = |errQ;
	// Write-one on the summary flag, or a UART data read, wipes the error set
	assign errClear = (wrStatus && regWrData[lin_regs_pkg::BIT_ERR])
		|| (dataRd && uartMode);

	// Control register: bit 6 revision, bit 0 UART mode
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			controlQ <= lin_regs_pkg::BYTE_ZERO;
		else if (wrControl)
			controlQ <= regWrData;
	end

	// Interrupt enables; upper bits are not stored, so they read zero
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			irqEnQ <= 4'h0;
		else if (wrIrqEn)
			irqEnQ <= regWrData[3:0];
	end

	// Error flags: a new event outweighs a clear in the same cycle
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			errQ <= lin_regs_pkg::BYTE_ZERO;
		else
			errQ <= (errClear ? lin_regs_pkg::BYTE_ZERO : errQ) | errEvents;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			idOkQ   <= 1'b0;
			txDoneQ <= 1'b0;
			rxDoneQ <= 1'b0;
		end
		else
		begin
			if (doneEvents.identOk)
				idOkQ <= 1'b1;
			else if (wrStatus && regWrData[lin_regs_pkg::BIT_ID])
				idOkQ <= 1'b0;
			if (doneEvents.txDone)
				txDoneQ <= 1'b1;
			else if ((wrStatus && regWrData[lin_regs_pkg::BIT_TX])
				|| (dataWr && uartMode))
				txDoneQ <= 1'b0;
			if (doneEvents.rxDone)
				rxDoneQ <= 1'b1;
			else if ((wrStatus && regWrData[lin_regs_pkg::BIT_RX])
				|| (dataRd && uartMode))
				rxDoneQ <= 1'b0;
		end
	end

	// Interrupt output is registered so it never glitches
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= (summaryErr && irqEnQ[lin_regs_pkg::BIT_ERR])
				|| (idOkQ && irqEnQ[lin_regs_pkg::BIT_ID])
				|| (txDoneQ && irqEnQ[lin_regs_pkg::BIT_TX])
				|| (rxDoneQ && irqEnQ[lin_regs_pkg::BIT_RX]);
	end

	// Bit timing; samples field writable at any time, provided the value is at least the minimum
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			resyncOffQ <= 1'b0;
			samplesQ   <= lin_regs_pkg::SAMPLES_RESET;
		end
		else if (wrTiming)
		begin
			resyncOffQ <= regWrData[lin_regs_pkg::BIT_RESYNC_OFF];
			// Below the minimum the samples value is refused to keep sampling sane
			if (regWrData[5:0] >= lin_regs_pkg::SAMPLES_MIN)
				samplesQ <= regWrData[5:0];
		end
	end

	// Halves land separately; no shadow, so the tick follows each half at once
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			divQ <= 12'h000;
		else if (wrDivLow)
			divQ[7:0] <= regWrData;
		else if (wrDivHigh)
			divQ[11:8] <= regWrData[3:0];
	end

	// Sample tick every divider+1 cycles
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			divCntQ <= 12'h000;
			tickQ   <= 1'b0;
		end
		else if (divCntQ >= divQ)
		begin
			divCntQ <= 12'h000;
			tickQ   <= 1'b1;
		end
		else
		begin
			divCntQ <= divCntQ + 12'h001;
			tickQ   <= 1'b0;
		end
	end

	assign timing.resyncEnable  = ~resyncOffQ;
	assign timing.samplesPerBit = samplesQ;
	assign timing.sampleTick    = tickQ;

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			lengthQ <= lin_regs_pkg::BYTE_ZERO;
		else if (wrLength)
			lengthQ <= regWrData;
	end

	always_comb
	begin
		unique case (lin_regs_pkg::legacy_len_e'(identQ[5:4]))
			lin_regs_pkg::LEN_CODE_2A: legacyLen = lin_regs_pkg::LEN_TWO;
			lin_regs_pkg::LEN_CODE_2B: legacyLen = lin_regs_pkg::LEN_TWO;
			lin_regs_pkg::LEN_CODE_4:  legacyLen = lin_regs_pkg::LEN_FOUR;
			lin_regs_pkg::LEN_CODE_8:  legacyLen = lin_regs_pkg::LEN_EIGHT;
		endcase
	end

	// Counts are zero in UART mode, where the fields mean nothing
	always_comb
	begin
		txByteCount = 4'h0;
		rxByteCount = 4'h0;
		if (!uartMode && legacyRevision)
		begin
			txByteCount = legacyLen;
			rxByteCount = legacyLen;
		end
		else if (!uartMode)
		begin
			txByteCount = (lengthQ[7:4] > lin_regs_pkg::BYTES_MAX)
				? lin_regs_pkg::BYTES_MAX : lengthQ[7:4];
			rxByteCount = (lengthQ[3:0] > lin_regs_pkg::BYTES_MAX)
				? lin_regs_pkg::BYTES_MAX : lengthQ[3:0];
		end
	end

	// Parity bits come from the engine, so they are not stored here
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			identQ <= lin_regs_pkg::BYTE_ZERO;
		else if (wrIdent)
			identQ <= {2'b00, regWrData[5:0]};
	end

	assign identValue = legacyRevision ? {2'b00, identQ[3:0]}
		: identQ[5:0];

	// Buffer select and index stepping
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			autoIncOffQ <= 1'b0;
			indexQ      <= 3'h0;
		end
		else if (wrSelect)
		begin
			autoIncOffQ <= regWrData[lin_regs_pkg::BIT_AUTOINC_OFF];
			indexQ      <= regWrData[2:0];
		end
		else if ((dataWr || dataRd) && !uartMode && !autoIncOffQ)
			indexQ <= indexQ + 3'h1;
	end

	// Response buffer: software port wins over the engine on a shared cycle
	always_ff @(posedge clock)
	begin
		if (dataWr && !uartMode)
			respBuf[indexQ] <= regWrData;
		else if (respWrValid)
			respBuf[respWrIndex] <= respWrByte;
	end

	// Engine read port, one cycle latency like the software port
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			respRdByte <= lin_regs_pkg::BYTE_ZERO;
		else
			respRdByte <= respBuf[respRdIndex];
	end

	// UART single byte registers, no buffering
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			uartRxQ     <= lin_regs_pkg::BYTE_ZERO;
			uartTxQ     <= lin_regs_pkg::BYTE_ZERO;
			uartTxLoadQ <= 1'b0;
		end
		else
		begin
			if (uartRxValid)
				uartRxQ <= uartRxByte;
			uartTxLoadQ <= dataWr && uartMode;
			if (dataWr && uartMode)
				uartTxQ <= regWrData;
		end
	end

	assign uartTxByte = uartTxQ;
	assign uartTxLoad = uartTxLoadQ;

	assign statusView = {4'h0, summaryErr, idOkQ, txDoneQ, rxDoneQ};

	always_comb
	begin
		unique case (regAddr)
			lin_regs_pkg::OFF_CONTROL:  rdMux = controlQ;
			lin_regs_pkg::OFF_STATUS:   rdMux = statusView;
			lin_regs_pkg::OFF_IRQ_EN:   rdMux = {4'h0, irqEnQ};
			lin_regs_pkg::OFF_ERROR:    rdMux = errQ;
			lin_regs_pkg::OFF_TIMING:   rdMux = {resyncOffQ, 1'b0, samplesQ};
			lin_regs_pkg::OFF_DIV_LOW:  rdMux = divQ[7:0];
			lin_regs_pkg::OFF_DIV_HIGH: rdMux = {4'h0, divQ[11:8]};
			lin_regs_pkg::OFF_LENGTH:   rdMux = lengthQ;
			lin_regs_pkg::OFF_IDENT:    rdMux = identQ;
			lin_regs_pkg::OFF_SELECT:   rdMux = {4'h0, autoIncOffQ, indexQ};
			lin_regs_pkg::OFF_DATA:     rdMux = uartMode ? uartRxQ : respBuf[indexQ];
			default:                    rdMux = lin_regs_pkg::BYTE_ZERO;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			rdDataQ <= lin_regs_pkg::BYTE_ZERO;
		else
			rdDataQ <= regRdStrobe ? rdMux : lin_regs_pkg::BYTE_ZERO;
	end

	assign regRdData = rdDataQ;
endmodule

// [dv/lin_regs_checker_assertions.sv]
// Port checker of the LIN/UART register set
`timescale 1ns/1ps
module lin_regs_checker
(
	// Clock and reset
	input wire logic                  clock,
	input wire logic                  rst_b,
	// Register port
	input wire logic [7:0]            regAddr,
	input wire logic [7:0]            regWrData,
	input wire logic                  regWrStrobe,
	input wire logic                  regRdStrobe,
	input wire logic [7:0]            regRdData,
	// Configuration
	input wire lin_regs_pkg::timing_s timing,
	input wire logic                  uartMode,
	input wire logic                  legacyRevision,
	input wire logic [3:0]            txByteCount,
	input wire logic [3:0]            rxByteCount,
	input wire logic [5:0]            identValue,
	input wire logic                  uartTxLoad
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_uart_counts_zero: assert property (uartMode |-> {txByteCount, rxByteCount} == 8'h00)
		else $error("byte counts not zero in UART mode");
	a_counts_by_write: assert property ($changed(txByteCount) |-> $past(regWrStrobe))
		else $error("transmit count moved without a write");
	a_samples_floor: assert property ($changed(timing.samplesPerBit) |->
		$past(regWrStrobe && regAddr == lin_regs_pkg::OFF_TIMING && regWrData[5:0] >= 6'h08))
		else $error("samples per bit changed without a legal write");
	a_legacy_len: assert property (legacyRevision && !uartMode |->
		txByteCount inside {4'h2, 4'h4, 4'h8} && rxByteCount == txByteCount)
		else $error("legacy response length not 2, 4 or 8");
	a_legacy_ident: assert property (legacyRevision |-> identValue[5:4] == 2'b00)
		else $error("legacy identifier wider than four bits");
	a_tx_load: assert property (uartTxLoad ==
		$past(regWrStrobe && regAddr == lin_regs_pkg::OFF_DATA && uartMode))
		else $error("transmit load not tied to a UART data write");
	a_timing_read: assert property (regRdStrobe && regAddr == lin_regs_pkg::OFF_TIMING |=>
		regRdData == {!$past(timing.resyncEnable), 1'b0, $past(timing.samplesPerBit)})
		else $error("timing readback differs from timing outputs");
	a_select_resv: assert property (regRdStrobe && regAddr == lin_regs_pkg::OFF_SELECT |=>
		regRdData[7:4] == 4'h0)
		else $error("reserved select bits read nonzero");
	cover property (legacyRevision && txByteCount == 4'h8);
	cover property (uartTxLoad);
	cover property (timing.sampleTick);
endmodule
bind lin_uart_register_set lin_regs_checker u_chk (.clock, .rst_b, .regAddr, .regWrData,
	.regWrStrobe, .regRdStrobe, .regRdData, .timing, .uartMode, .legacyRevision,
	.txByteCount, .rxByteCount, .identValue, .uartTxLoad);

// [dv/lin_engine_model.sv]
// Protocol engine stand-in raising event pulses
`timescale 1ns/1ps
module lin_engine_model
(
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	// Bench commands
	input  wire logic                  kick,
	input  wire logic [7:0]            evByte,
	input  wire logic [2:0]            evDone,
	// Toward the register set
	output lin_regs_pkg::err_events_s  errEvents,
	output lin_regs_pkg::done_events_s doneEvents,
	output logic                       uartRxValid,
	output logic      [7:0]            uartRxByte
);
	// Idle byte toggles so a stale value never looks valid
	always_ff @(posedge clock)
	begin
		errEvents   <= (kick && rst_b) ? evByte : 8'h00;
		doneEvents  <= (kick && rst_b) ? evDone : 3'h0;
		uartRxValid <= kick && rst_b;
		uartRxByte  <= kick ? evByte : (rst_b ? ~uartRxByte : 8'h00);
	end
endmodule

// [dv/tb_lin_uart_register_set.sv]
// Self-checking bench of the LIN/UART register set
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errors++; $display("ERROR %0t %h/%h", $time, a, b); end end
module tb_lin_uart_register_set;
	logic                       clock = 0, rst_b = 0, regWrStrobe = 0, regRdStrobe = 0;
	logic [7:0]                 regAddr = 0, regWrData = 0, evByte = 0, q, regRdData;
	logic [7:0]                 uartRxByte, respRdByte, uartTxByte, b [3];
	logic                       kick = 0, irq, uartTxLoad, uartRxValid, uartMode, legacyRevision;
	logic [2:0]                 respRdIndex = 0, evDone = 0, respWrIndex = 0;
	logic                       respWrValid = 0;
	logic [7:0]                 respWrByte = 0;
	logic [3:0]                 txByteCount, rxByteCount;
	logic [5:0]                 identValue;
	lin_regs_pkg::err_events_s  errEvents;
	lin_regs_pkg::done_events_s doneEvents;
	lin_regs_pkg::timing_s      timing;
	logic [7:0]                 tw [4] = '{8'h85, 8'h3f, 8'h08, 8'h87};
	logic [7:0]                 te [4] = '{8'ha0, 8'h3f, 8'h08, 8'h88};
	integer                     errors = 0, nTests = 0, seed = 96, i, n, cnt;
	always #25 clock = ~clock;
	lin_engine_model u_eng (.clock, .rst_b, .kick, .evByte, .evDone, .errEvents, .doneEvents,
		.uartRxValid, .uartRxByte);
	lin_uart_register_set u_dut (.clock, .rst_b, .regAddr, .regWrData, .regWrStrobe,
		.regRdStrobe, .regRdData, .errEvents, .doneEvents, .uartRxValid, .uartRxByte,
		.respWrValid, .respWrIndex, .respWrByte, .respRdIndex, .timing,
		.uartMode, .legacyRevision, .txByteCount, .rxByteCount, .identValue, .respRdByte,
		.uartTxByte, .uartTxLoad, .irq);
	task automatic testDone;
		if (errors == 0 && nTests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr     <= a;
		regWrData   <= d;
		regWrStrobe <= 1'b1;
		@(posedge clock);
		regWrStrobe <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		regAddr     <= a;
		regRdStrobe <= 1'b1;
		@(posedge clock);
		regRdStrobe <= 1'b0;
		#1 q = regRdData;
	endtask
	// Waits out the event path and the registered interrupt
	task automatic pulse(input logic [7:0] e, input logic [2:0] d);
		@(posedge clock);
		evByte <= e;
		evDone <= d;
		kick   <= 1'b1;
		@(posedge clock);
		kick <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic waitTick(output integer c);
		c = 0;
		do
		begin
			@(posedge clock);
			#1 c++;
			if (c > 5000)
			begin
				errors++;
				testDone;
			end
		end while (timing.sampleTick !== 1'b1);
	endtask
	function automatic logic [3:0] lenOf(input logic [1:0] c);
		return c[1] ? (c[0] ? 4'h8 : 4'h4) : 4'h2;
	endfunction
	initial
	begin
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		for (i = 8'hc8; i < 8'hd4; i++)
			if (i != 8'hd2)
			begin
				rd(i[7:0]);
				`CHK(q, (i == 8'hcc) ? 8'h20 : 8'h00)
			end
		for (i = 0; i < 4; i++)
		begin
			wr(lin_regs_pkg::OFF_IRQ_EN, {4'h0, i[0], 3'h0});
			pulse((i == 0) ? 8'hff : 8'($random(seed)) | 8'h01, 3'h0);
			rd(lin_regs_pkg::OFF_ERROR);
			`CHK(q, evByte)
			`CHK(irq, i[0])
			rd(lin_regs_pkg::OFF_STATUS);
			`CHK(q[3], 1'b1)
			wr(lin_regs_pkg::OFF_STATUS, 8'h08);
			rd(lin_regs_pkg::OFF_ERROR);
			`CHK({irq, q}, 9'h000)
		end
		for (i = 0; i < 3; i++)
		begin
			wr(lin_regs_pkg::OFF_IRQ_EN, 8'h0f ^ (8'h01 << i));
			pulse(8'h00, 3'h1 << i);
			`CHK(irq, 1'b0)
			wr(lin_regs_pkg::OFF_IRQ_EN, 8'h01 << i);
			repeat (2) @(posedge clock);
			#1 `CHK(irq, 1'b1)
			wr(lin_regs_pkg::OFF_STATUS, 8'h01 << i);
			repeat (2) @(posedge clock);
			#1 `CHK(irq, 1'b0)
		end
		for (i = 0; i < 4; i++)
		begin
			wr(lin_regs_pkg::OFF_TIMING, tw[i]);
			rd(lin_regs_pkg::OFF_TIMING);
			`CHK({q, timing.resyncEnable}, {te[i], !te[i][7]})
		end
		for (i = 0; i < 2; i++)
		begin
			n = i ? 12'hfff : $random(seed) & 15;
			wr(lin_regs_pkg::OFF_DIV_LOW, n[7:0]);
			wr(lin_regs_pkg::OFF_DIV_HIGH, {4'h0, n[11:8]});
			waitTick(cnt);
			waitTick(cnt);
			`CHK(cnt, n + 1)
		end
		wr(lin_regs_pkg::OFF_LENGTH, 8'h9a);
		`CHK({txByteCount, rxByteCount}, 8'h88)
		wr(lin_regs_pkg::OFF_LENGTH, 8'h35);
		`CHK({txByteCount, rxByteCount}, 8'h35)
		wr(lin_regs_pkg::OFF_CONTROL, 8'h40);
		for (i = 0; i < 4; i++)
		begin
			wr(lin_regs_pkg::OFF_IDENT, {2'b00, i[1:0], 4'h9});
			`CHK({txByteCount, identValue}, {lenOf(i[1:0]), 6'h09})
		end
		wr(lin_regs_pkg::OFF_CONTROL, 8'h00);
		wr(lin_regs_pkg::OFF_IDENT, 8'hed);
		`CHK({legacyRevision, identValue, txByteCount}, 11'h2d3)
		wr(lin_regs_pkg::OFF_SELECT, 8'h05);
		for (i = 0; i < 3; i++)
		begin
			b[i] = 8'($random(seed));
			wr(lin_regs_pkg::OFF_DATA, b[i]);
		end
		rd(lin_regs_pkg::OFF_SELECT);
		`CHK(q, 8'h00)
		@(posedge clock);
		respRdIndex <= 3'h6;
		repeat (2) @(posedge clock);
		#1 `CHK(respRdByte, b[1])
		wr(lin_regs_pkg::OFF_SELECT, 8'h0f);
		rd(lin_regs_pkg::OFF_DATA);
		`CHK(q, b[2])
		rd(lin_regs_pkg::OFF_SELECT);
		`CHK(q, 8'h0f)
		@(posedge clock);
		respWrIndex <= 3'h7;
		respWrByte  <= ~b[2];
		respWrValid <= 1'b1;
		@(posedge clock);
		respWrValid <= 1'b0;
		rd(lin_regs_pkg::OFF_DATA);
		`CHK(q, ~b[2])
		wr(lin_regs_pkg::OFF_CONTROL, 8'h01);
		`CHK({uartMode, txByteCount, rxByteCount}, 9'h100)
		wr(lin_regs_pkg::OFF_DATA, 8'h5a);
		pulse(8'hc3, 3'h0);
		`CHK(uartTxByte, 8'h5a)
		rd(lin_regs_pkg::OFF_DATA);
		`CHK(q, 8'hc3)
		testDone;
	end
endmodule
